/* File: core/vfc_pkg.sv */
package vfc_pkg;

   // Control codes carried in the byte stream.
   localparam logic [7:0] CODE_DC2 = 8'h12;
   localparam logic [7:0] CODE_DC3 = 8'h13;
   localparam logic [7:0] CODE_DC4 = 8'h14;
   localparam logic [7:0] CMD_FORCE = 8'h80;

   // Command byte field positions, bit 7 being the leftmost bit.
   localparam int CMD_TYPE_BIT = 4;
   localparam int CMD_SEL_BIT = 6;

   // Format memory geometry.
   localparam int LINE_W = 8;
   localparam int CHANS = 12;
   localparam logic [LINE_W-1:0] MEM_LINES = 8'h8F;
   localparam logic [3:0] CHAN_LIMIT = 4'hC;
   localparam logic [3:0] CH_TOF = 4'h0;
   localparam logic [3:0] CH_INV_LO = 4'h5;
   localparam logic [3:0] CH_BOF = 4'hB;

   // Perforation skipover without a loaded format.
   localparam int FORM_W = 7;
   localparam logic [FORM_W-1:0] DEF_PRINT_LINES = 7'h3F;
   localparam logic [FORM_W-1:0] DEF_FORM_LINES = 7'h42;
   localparam logic [LINE_W-1:0] DEF_SKIP_LINES = 8'h03;

   // Stream buffer.
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 32;

   // Reset values.
   localparam logic [LINE_W-1:0] RST_LINE = 8'h00;
   localparam logic [FORM_W-1:0] RST_FORM = 7'h00;

   typedef enum {
      VFC_IDLE,
      VFC_STEP,
      VFC_WAIT
   } vfc_state_t;

   typedef enum {
      VFC_ADV,
      VFC_SEL,
      VFC_PERF
   } vfc_mode_t;

   typedef struct packed {
      logic load_active;
      logic format_loaded;
      logic load_error;
      logic select_error;
      logic top_of_form;
      logic bottom_of_form;
      logic busy;
   } vfc_status_t;

endpackage : vfc_pkg

/* File: core/vfc_fifo.sv */
`timescale 1ns/1ns
module vfc_fifo
   import vfc_pkg::*;
#(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic rdy;
   } vfc_fifo_st_t;

   vfc_fifo_st_t q;
   vfc_fifo_st_t next_q;
   logic [W-1:0] mem [DEPTH];
   logic push;
   logic pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : bump

   assign out_valid = (q.cnt != '0);
   assign out_data = mem[q.rp];
   assign in_ready = q.rdy;

   always_comb begin
      next_q = q;
      push = in_valid && q.rdy;
      pop = out_valid && out_ready;
      if (push) begin
         next_q.wp = bump(q.wp);
      end
      if (pop) begin
         next_q.rp = bump(q.rp);
      end
      next_q.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      // Ready is registered so the stream port sees a clean flop output.
      next_q.rdy = (next_q.cnt != FULL);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
      end else begin
         q <= next_q;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[q.wp] <= in_data;
      end
   end

   chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
      q.cnt <= FULL) else $error("fifo count above depth");

endmodule : vfc_fifo

/* File: core/vfc_core.sv */
`timescale 1ns/1ns
// Operation
// (R01) Fourth bit zero means channel select
// (R02) Sender loads format before channel select
// (R03) Step one location per line until stop
// (R04) Memory is 143 lines of 12 channels
// (R05) Code 23 octal starts format load
// (R06) Two bytes per line, 286 max, 24 ends
// (R07) Odd byte channels 1-6, even 7-12
// (R08) No half line is ever stored
// (R09) Short loads are valid formats
// (R10) Full load without end code flags error
// (R11) Loaded first line aligns to print line
// (R12) Channel one set marks top of form
// (R13) Later end code realigns the memory
// (R14) Only the byte after 22 is command
// (R15) Select: bits one one x zero, chan-1
// (R16) Variant inverts channels six and twelve
// (R17) Skip perforation after bottom of form
// (R18) Unloaded: 63 printed lines, 3 skipped
// (R19) Loaded: channel twelve bottom, skip to top
// (R20) Sender marks top and bottom once each
// (R21) Code 22 octal prefixes a command
// (R22) Leftmost command bit is forced to one
// (R23) Fourth bit one advances low-nibble count
// (R24) Position wraps after the last loaded line
// (R25) Failed channel search stops with error
module vfc_core
   import vfc_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [BYTE_W-1:0] byte_data,
   input wire logic byte_valid,
   output logic byte_ready,
   input wire logic paper_ready,
   input wire logic variant_inv,
   output logic paper_step,
   output vfc_status_t status
);

   typedef struct packed {
      vfc_state_t st;
      vfc_mode_t mode;
      logic dc2;
      logic loading;
      logic loaded;
      logic half;
      logic [5:0] lo6;
      logic [LINE_W-1:0] wcnt;
      logic [LINE_W-1:0] nlines;
      logic [LINE_W-1:0] pos;
      logic [LINE_W-1:0] remain;
      logic [FORM_W-1:0] flin;
      logic [3:0] chan;
      logic [2:0] psync;
      logic prdy;
      logic [2:0] vsync;
      logic vinv;
      logic step;
      vfc_status_t stat;
   } vfc_core_st_t;

   localparam vfc_core_st_t RST_STATE = '{
      st: VFC_IDLE, mode: VFC_ADV, dc2: 1'b0, loading: 1'b0, loaded: 1'b0, half: 1'b0,
      lo6: '0, wcnt: RST_LINE, nlines: RST_LINE, pos: RST_LINE, remain: RST_LINE,
      flin: RST_FORM, chan: '0, psync: '0, prdy: 1'b0, vsync: '0, vinv: 1'b0,
      step: 1'b0, stat: '0};

   vfc_core_st_t q;
   vfc_core_st_t next_q;
   logic [1:0] rst_sync;
   logic rst_n;
   logic [BYTE_W-1:0] fb_data;
   logic fb_valid;
   logic take;
   logic [CHANS-1:0] fmt_mem [MEM_LINES];
   logic [CHANS-1:0] word;
   logic wr_en;
   logic [CHANS-1:0] wr_data;
   logic [BYTE_W-1:0] cmd;
   logic tof_here;
   logic bof_here;
   logic fin;

   // A stop test that honours the inverted-sense channels of some printers.
   function automatic logic stop_at(input logic [CHANS-1:0] w, input logic [3:0] ch,
                                    input logic inv);
      logic b;
      b = w[ch];
      if (inv && (ch == CH_INV_LO || ch == CH_BOF)) begin // [R16]
         b = ~b;
      end
      stop_at = b;
   endfunction : stop_at

   function automatic logic [LINE_W-1:0] next_line(input logic [LINE_W-1:0] p,
                                                   input logic [LINE_W-1:0] n);
      next_line = (LINE_W'(p + 1'b1) >= n) ? RST_LINE : LINE_W'(p + 1'b1);
   endfunction : next_line

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   vfc_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(byte_data),
      .in_valid(byte_valid),
      .in_ready(byte_ready),
      .out_data(fb_data),
      .out_valid(fb_valid),
      .out_ready(take)
   );

   assign word = fmt_mem[q.pos];
   assign paper_step = q.step;
   assign status = q.stat;

   always_comb begin
      next_q = q;
      next_q.step = 1'b0;
      take = 1'b0;
      wr_en = 1'b0;
      wr_data = {fb_data[5:0], q.lo6}; // [R07]
      cmd = fb_data | CMD_FORCE; // [R22]
      fin = 1'b0;
      // Pins pass three flops; a level counts once the last two agree.
      next_q.psync = {q.psync[1:0], paper_ready};
      if (q.psync[1] == q.psync[2]) begin
         next_q.prdy = q.psync[2];
      end
      next_q.vsync = {q.vsync[1:0], variant_inv};
      if (q.vsync[1] == q.vsync[2]) begin
         next_q.vinv = q.vsync[2];
      end
      tof_here = q.loaded ? stop_at(word, CH_TOF, q.vinv) : (q.flin == RST_FORM); // [R12]
      bof_here = q.loaded ? stop_at(word, CH_BOF, q.vinv) // [R19]
                          : (q.flin == DEF_PRINT_LINES); // [R18]
      case (q.st)
         VFC_IDLE: begin
            if (fb_valid) begin
               take = 1'b1;
               if (q.loading) begin
                  if (fb_data == CODE_DC4) begin
                     // A dangling half line is dropped here.
                     next_q.loading = 1'b0; // [R06]
                     next_q.half = 1'b0; // [R08]
                     if (q.wcnt != RST_LINE) begin
                        next_q.loaded = 1'b1; // [R09]
                        next_q.nlines = q.wcnt;
                        next_q.pos = RST_LINE; // [R11]
                     end
                  end else if (q.wcnt == MEM_LINES) begin
                     // The full format is kept; only the missing end code is reported.
                     next_q.loading = 1'b0;
                     next_q.loaded = 1'b1;
                     next_q.nlines = MEM_LINES;
                     next_q.pos = RST_LINE;
                     next_q.stat.load_error = 1'b1; // [R10]
                  end else if (!q.half) begin
                     next_q.lo6 = fb_data[5:0]; // [R07]
                     next_q.half = 1'b1;
                  end else begin
                     wr_en = 1'b1; // [R04] [R06]
                     next_q.wcnt = LINE_W'(q.wcnt + 1'b1);
                     next_q.half = 1'b0;
                  end
               end else if (q.dc2) begin
                  next_q.dc2 = 1'b0; // [R14]
                  if (cmd[CMD_TYPE_BIT]) begin
                     next_q.mode = VFC_ADV; // [R23]
                     next_q.remain = {4'h0, cmd[3:0]};
                     next_q.st = VFC_STEP;
                  end else if (cmd[CMD_SEL_BIT] && cmd[3:0] < CHAN_LIMIT) begin // [R01] [R15]
                     if (q.loaded) begin
                        next_q.mode = VFC_SEL;
                        next_q.chan = cmd[3:0];
                        next_q.remain = q.nlines;
                        next_q.st = VFC_STEP;
                        next_q.stat.select_error = 1'b0;
                     end else begin
                        // Without stored stops there is nothing to search for.
                        next_q.stat.select_error = 1'b1; // [R02]
                     end
                  end
               end else if (fb_data == CODE_DC2) begin
                  next_q.dc2 = 1'b1; // [R21]
               end else if (fb_data == CODE_DC3) begin
                  next_q.loading = 1'b1; // [R05]
                  next_q.loaded = 1'b0;
                  next_q.wcnt = RST_LINE;
                  next_q.half = 1'b0;
                  next_q.pos = RST_LINE;
                  next_q.stat.load_error = 1'b0;
               end else if (fb_data == CODE_DC4 && q.loaded) begin
                  next_q.pos = RST_LINE; // [R13]
               end
            end
         end
         VFC_STEP: begin
            case (q.mode)
               VFC_ADV: fin = (q.remain == RST_LINE);
               VFC_SEL: fin = (q.remain != q.nlines) && stop_at(word, q.chan, q.vinv); // [R03]
               // The skip always leaves the bottom line, even when that line also marks top.
               VFC_PERF: fin = (q.remain == RST_LINE)
                               || (q.loaded && tof_here && q.remain != q.nlines); // [R19]
               default: fin = 1'b1;
            endcase
            if (fin) begin
               if (q.mode != VFC_PERF && bof_here) begin
                  next_q.mode = VFC_PERF; // [R17]
                  next_q.remain = q.loaded ? q.nlines : DEF_SKIP_LINES; // [R18]
               end else begin
                  next_q.st = VFC_IDLE;
               end
            end else if (q.mode == VFC_SEL && q.remain == RST_LINE) begin
               next_q.stat.select_error = 1'b1; // [R25]
               next_q.st = VFC_IDLE;
            end else if (q.prdy) begin
               next_q.step = 1'b1;
               next_q.pos = q.loaded ? next_line(q.pos, q.nlines) : RST_LINE; // [R24]
               next_q.flin = (q.flin == DEF_FORM_LINES - 1'b1) ? RST_FORM
                                                                : FORM_W'(q.flin + 1'b1);
               next_q.remain = LINE_W'(q.remain - 1'b1);
               next_q.st = VFC_WAIT;
            end
         end
         VFC_WAIT: begin
            // The mechanism drops ready while a line is moving.
            if (!q.prdy) begin
               next_q.st = VFC_STEP;
            end
         end
         default: next_q.st = VFC_IDLE;
      endcase
      next_q.stat.load_active = next_q.loading;
      next_q.stat.format_loaded = next_q.loaded;
      next_q.stat.top_of_form = tof_here;
      next_q.stat.bottom_of_form = bof_here;
      next_q.stat.busy = (next_q.st != VFC_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST_STATE;
      end else begin
         q <= next_q;
      end
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         fmt_mem[q.wcnt] <= wr_data; // [R04]
      end
   end

   chk_sel_decode: assert property (@(posedge clk) disable iff (!rst_n) // [R01] [R15]
      take && q.dc2 && !q.loading && q.loaded && !fb_data[CMD_TYPE_BIT]
      && fb_data[CMD_SEL_BIT] && fb_data[3:0] < CHAN_LIMIT
      |=> q.st == VFC_STEP && q.mode == VFC_SEL && q.chan == $past(fb_data[3:0]))
      else $error("channel select not decoded");

   chk_adv_count: assert property (@(posedge clk) disable iff (!rst_n) // [R23]
      take && q.dc2 && !q.loading && fb_data[CMD_TYPE_BIT]
      |=> q.mode == VFC_ADV && q.remain == {4'h0, $past(fb_data[3:0])})
      else $error("line count advance not decoded");

   chk_load_enter: assert property (@(posedge clk) disable iff (!rst_n) // [R05]
      take && !q.loading && !q.dc2 && fb_data == CODE_DC3
      |=> q.loading && q.wcnt == RST_LINE && !q.half)
      else $error("load mode not entered");

   chk_load_word: assert property (@(posedge clk) disable iff (!rst_n) // [R06]
      wr_en |-> q.half && q.wcnt < MEM_LINES ##1 q.wcnt == $past(q.wcnt) + 1'b1)
      else $error("line store out of order");

   chk_even_store: assert property (@(posedge clk) disable iff (!rst_n) // [R08]
      take && q.loading && fb_data == CODE_DC4 |=> !q.half && !q.loading
      && q.wcnt == $past(q.wcnt))
      else $error("half line kept after end code");

   chk_load_align: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
      take && q.loading && fb_data == CODE_DC4 && q.wcnt != RST_LINE
      |=> q.loaded && q.pos == RST_LINE && q.nlines == $past(q.wcnt))
      else $error("format not aligned after load");

   chk_full_error: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
      take && q.loading && q.wcnt == MEM_LINES && fb_data != CODE_DC4
      |=> q.stat.load_error ##1 q.stat.load_error)
      else $error("overlong load not reported");

   chk_pos_wrap: assert property (@(posedge clk) disable iff (!rst_n) // [R24]
      q.loaded && !q.loading |-> q.pos < q.nlines)
      else $error("position beyond loaded lines");

   chk_step_pace: assert property (@(posedge clk) disable iff (!rst_n) // [R03]
      q.step |-> q.st == VFC_WAIT ##1 !q.step [*3])
      else $error("paper steps too close together");

   chk_default_form: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
      !q.loaded && q.step && $past(q.flin) == DEF_FORM_LINES - 1'b1
      |-> q.flin == RST_FORM)
      else $error("default form length wrong");

   chk_sel_stop: assert property (@(posedge clk) disable iff (!rst_n) // [R03]
      q.st == VFC_STEP && q.mode == VFC_SEL && q.remain != q.nlines
      && stop_at(word, q.chan, q.vinv)
      |=> !q.step && (q.st == VFC_IDLE || q.mode == VFC_PERF))
      else $error("channel select ran past its stop");

   chk_sel_fail: assert property (@(posedge clk) disable iff (!rst_n) // [R25]
      q.st == VFC_STEP && q.mode == VFC_SEL && q.remain == RST_LINE
      && !stop_at(word, q.chan, q.vinv) |=> q.stat.select_error && q.st == VFC_IDLE)
      else $error("failed channel search not reported");

   chk_perf_start: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
      q.st == VFC_STEP && q.mode != VFC_PERF && fin && bof_here
      |=> q.st == VFC_STEP && q.mode == VFC_PERF)
      else $error("bottom of form not skipped");

   chk_no_prefix: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
      take && !q.loading && !q.dc2 |=> q.st == VFC_IDLE && !q.step)
      else $error("byte without prefix moved paper");

   chk_top_mark: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
      q.loaded && word[CH_TOF] |=> q.stat.top_of_form)
      else $error("channel one stop not shown as top of form");

   chk_inv_bottom: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
      q.loaded && q.vinv && !word[CH_BOF] |=> q.stat.bottom_of_form)
      else $error("inverted bottom channel misread");

   chk_form_bottom: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
      !q.loaded && q.flin == DEF_PRINT_LINES |=> q.stat.bottom_of_form)
      else $error("default bottom of form missed");

   chk_end_realign: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
      take && !q.loading && !q.dc2 && q.loaded && fb_data == CODE_DC4
      |=> q.pos == RST_LINE)
      else $error("end code did not realign the memory");

endmodule : vfc_core

/* File: verification/vfc_paper_model.sv */
`timescale 1ns/1ns
module vfc_paper_model (
   input wire logic clk,
   input wire logic paper_step,
   input wire logic slow,
   output logic paper_ready,
   output int steps
);
   int hold = 0;
   // Ready falls after every line, long enough that the core's synchroniser sees the low phase.
   initial begin
      paper_ready = 1'b1;
      steps = 0;
   end
   always @(posedge clk) begin
      if (paper_step === 1'b1) begin
         steps <= steps + 1;
         paper_ready <= 1'b0;
         hold <= slow ? 20 : 5;
      end else if (hold > 1) begin
         hold <= hold - 1;
      end else if (hold == 1) begin
         hold <= 0;
         paper_ready <= 1'b1;
      end
   end
endmodule : vfc_paper_model

/* File: verification/vertical_format_unit_control_test.sv */
`timescale 1ns/1ns
module vertical_format_unit_control_test;
   import vfc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] byte_data = 8'h00;
   logic byte_valid = 1'b0;
   logic byte_ready;
   logic paper_ready;
   logic variant_inv = 1'b0;
   logic paper_step;
   logic slow = 1'b0;
   vfc_status_t status;
   int steps;
   int errors = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'h00014AC8;
   int mem[$];
   int nl = 0;
   int pos = 0;
   int ld = 0;
   int inv = 0;
   int serr = 0;
   int lerr = 0;
   int last = 0;
   int exp_n = 0;
   // Top marked once on line 0 and bottom once on line 4.
   logic [7:0] tbl[12] = '{8'h41, 8'h40, 8'h40, 8'h40, 8'h40, 8'h41,
                           8'h44, 8'h40, 8'h40, 8'h60, 8'h40, 8'h40};

   always #10 clk = ~clk;

   vfc_core #(.DEPTH(FIFO_DEPTH)) dut (.clk(clk), .nrst(nrst), .byte_data(byte_data),
      .byte_valid(byte_valid), .byte_ready(byte_ready), .paper_ready(paper_ready),
      .variant_inv(variant_inv), .paper_step(paper_step), .status(status));
   vfc_paper_model paper (.clk(clk), .paper_step(paper_step), .slow(slow),
      .paper_ready(paper_ready), .steps(steps));

   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function int stp(input int l, input int c);
      int b;
      b = (mem[l] >> c) & 1;
      if (inv != 0 && (c == 5 || c == 11)) b = 1 - b;
      return b;
   endfunction : stp

   function int is_top();
      return ld ? stp(pos, 0) : int'(pos == 0);
   endfunction : is_top

   function int is_bot();
      return ld ? stp(pos, 11) : int'(pos == 63);
   endfunction : is_bot

   task mv;
      pos = (pos + 1) % (ld ? nl : 66);
      exp_n++;
   endtask : mv

   task m_skip;
      int i;
      if (is_bot() != 0) begin
         if (ld == 0) for (i = 0; i < 3; i++) mv();
         else for (i = 0; i == 0 || (i < nl && stp(pos, 0) == 0); i++) mv();
      end
   endtask : m_skip

   // Bytes are offered on falling edges and held until an edge with ready high takes them.
   task put(input logic [7:0] b);
      int k;
      logic r;
      @(negedge clk);
      byte_data = b;
      byte_valid = 1'b1;
      for (k = 0; k < 5000; k++) begin
         r = byte_ready;
         @(posedge clk);
         if (r === 1'b1) break;
         @(negedge clk);
      end
      @(negedge clk);
      byte_valid = 1'b0;
      byte_data = ~b;
      if (k >= 5000) begin
         errors++;
         stop_test();
      end
   endtask : put

   // A command byte always follows the prefix code.
   task cmd(input logic [7:0] b);
      logic [7:0] c;
      int i;
      put(CODE_DC2);
      put(b);
      c = b | 8'h80;
      if (c[4]) begin
         for (i = 0; i < c[3:0]; i++) mv();
         m_skip();
      end else if (c[6] && c[3:0] < 12) begin
         if (ld == 0) serr = 1;
         else begin
            for (i = 0; i == 0 || (i < nl && stp(pos, c[3:0]) == 0); i++) mv();
            serr = stp(pos, c[3:0]) == 0;
            if (serr == 0) m_skip();
         end
      end
   endtask : cmd

   task settle;
      int k;
      int q;
      q = 0;
      // Forty idle cycles also let a full stream buffer drain before the next check.
      for (k = 0; k < 30000 && q < 40; k++) begin
         @(negedge clk);
         q = (status.busy === 1'b0) ? q + 1 : 0;
      end
      if (k >= 30000) begin
         errors++;
         stop_test();
      end
   endtask : settle

   task check_all(input int id);
      settle();
      chk(steps - last, exp_n);
      last = steps;
      exp_n = 0;
      chk(status.top_of_form, is_top());
      chk(status.bottom_of_form, is_bot());
      chk(status.select_error, serr);
      chk(status.format_loaded, ld);
      chk(status.load_error, lerr);
      chk(status.load_active, 0);
      chk(byte_ready, 1'b1);
      seed = lfsr(seed);
      slow = seed[0];
      $display("test %0d done", id);
   endtask : check_all

   // Each line takes two bytes; the upper two bits of every data byte are 01, and only the lower six carry channels.
   task load(input int n, input int odd, input int fin);
      int i;
      logic [7:0] a;
      logic [7:0] b;
      put(CODE_DC3);
      ld = 0;
      mem.delete();
      lerr = 0;
      repeat (4) @(negedge clk);
      chk(status.load_active, 1);
      for (i = 0; i < n; i++) begin
         seed = lfsr(seed);
         a = (n > 6) ? {2'h1, seed[5:0]} : tbl[2 * i];
         b = (n > 6) ? {2'h1, seed[13:8]} : tbl[2 * i + 1];
         mem.push_back(int'(a[5:0]) | (int'(b[5:0]) << 6));
         put(a);
         put(b);
      end
      if (odd != 0) put(8'h7F);
      if (fin != 0) begin
         put(CODE_DC4);
         ld = n > 0;
         nl = n;
         pos = 0;
      end else begin
         put(8'h40);
         lerr = 1;
         ld = 1;
         nl = n;
         pos = 0;
      end
   endtask : load

   initial begin
      int i;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      check_all(0);
      for (i = 0; i < 16; i++) cmd(8'h10 | i[7:0]);
      check_all(1);
      cmd(8'h19);
      // A control code behind the prefix is a command, not a load start.
      cmd(8'h13);
      check_all(2);
      // A select before any load is refused without motion.
      cmd(8'h40);
      cmd(8'h05);
      cmd(8'h4D);
      // Unprefixed bytes queue behind a long advance until the buffer is full.
      cmd(8'h1F);
      for (i = 0; i < FIFO_DEPTH; i++) put(8'h40);
      chk(byte_ready, 1'b0);
      check_all(3);
      load(6, 0, 1);
      check_all(4);
      for (i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         cmd(8'h40 | (seed[7:0] & 8'h20) | i[7:0]);
         check_all(5);
      end
      variant_inv = 1'b1;
      inv = 1;
      repeat (6) @(negedge clk);
      cmd(8'h45);
      check_all(6);
      variant_inv = 1'b0;
      inv = 0;
      repeat (6) @(negedge clk);
      cmd(8'h91);
      put(CODE_DC4);
      pos = 0;
      check_all(7);
      load(1, 1, 1);
      cmd(8'h40);
      check_all(8);
      load(143, 0, 0);
      settle();
      chk(status.load_error, 1);
      chk(status.format_loaded, 1);
      $display("test 9 done");
      stop_test();
   end
endmodule : vertical_format_unit_control_test
